// ### core/rsr_core.sv
// Reset source recorder: merges seven reset requests into the internal
// reset, records the cause byte, keeps detector settings across
// detector resets and drives post-reset values to peripherals.
// Assumes all requests arrive synchronous to clock except the pin and
// supply detector levels, which are synchronised here.
//
// Overview of operation
// - Cause byte: 7 opcode, 4 watchdog, 2 parity, 1 access, 0 lowv.
// - Pin reset, power-on reset and a cause read clear all cause flags.
// - Illegal-opcode reset sets its flag only.
// - Executing instruction byte FFH raises illegal-opcode reset.
// - No illegal-opcode reset while under a debug emulator.
// - Watchdog overflow reset sets its flag only.
// - RAM parity error reset sets its flag only.
// - Illegal memory access reset sets its flag only.
// - Low-voltage detector reset sets its flag only.
// - Other resets clear detector control; a detector reset keeps it.
// - Non-detector resets load level 00H/81H/01H by option mode.
// - During reset only the program counter is undefined.
// - Reset at power-up and supply fall; released on supply rise.
// - Every reset clears the parity-reset-disable control.
// - Reset clears request flags, sets mask and priority flags to FFH.
// - Reset loads serial mode 0020H, setting 0087H, output 0F0FH.
// - Reset loads compare limits FFH/00H and clears conversion result.
// - Detector interrupt in interrupt-and-reset mode sets level bits.
`timescale 1ns/1ps
module rsr_core (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Reset requests
   input wire rsr_pkg::rsr_req_t req,
   input wire logic [7:0] exec_opcode,
   input wire logic exec_valid,
   input wire logic debug_mode,
   // Option byte detector mode
   input wire logic detector_option_mode_hi,
   input wire logic detector_option_mode_lo,
   input wire logic voltage_drop_interrupt,
   // SFR port
   input wire logic [19:0] sfr_addr,
   input wire logic sfr_rd,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic det_ctrl_wr,
   input wire logic det_level_wr,
   input wire logic parity_dis_wr,
   output logic [7:0] sfr_rdata,
   // Reset outputs and held settings
   output logic internal_reset,
   output logic pc_undefined,
   output logic [7:0] voltage_detect_control,
   output logic [7:0] detection_level_select,
   output logic parity_reset_disable,
   output logic [7:0] reset_cause_flags,
   output rsr_pkg::rsr_init_t init_values
);

   rsr_pkg::rsr_state_t st_r;
   rsr_pkg::rsr_state_t st_nxt;
   rsr_pkg::rsr_init_t init_r;
   rsr_pkg::rsr_init_t init_nxt;

   // Two-flop synchronisers for pin and supply detector levels
   logic [2:0] async_in;
   logic [2:0] sync_a_r;
   logic [2:0] sync_b_r;
   assign async_in = {req.pin, req.supply_fall, req.supply_rise};

   always_ff @(posedge clock) begin
      if (reset) begin
         sync_a_r <= 3'h0;
         sync_b_r <= 3'h0;
      end else begin
         sync_a_r <= async_in;
         sync_b_r <= sync_a_r;
      end
   end

   logic pin_s;
   logic fall_s;
   logic rise_s;
   assign pin_s = sync_b_r[2];
   assign fall_s = sync_b_r[1];
   assign rise_s = sync_b_r[0];

   logic opcode_req;
   logic por_req;
   logic clear_src;
   logic any_rst;
   logic lvd_only;
   logic cause_rd;
   logic [7:0] lvl_default;

   always_comb begin
      st_nxt = st_r;
      init_nxt = init_r;
      // Illegal instruction, suppressed under debug
      opcode_req = req.opcode
         | (exec_valid && exec_opcode == rsr_pkg::OPCODE_ILLEGAL
            && !debug_mode);
      if (debug_mode) begin
         opcode_req = 1'b0;
      end
      // Supply monitor: fall asserts, rise releases
      if (fall_s) begin
         st_nxt.power_ok = 1'b0;
      end else if (rise_s) begin
         st_nxt.power_ok = 1'b1;
      end
      por_req = !st_r.power_ok || fall_s;
      clear_src = pin_s || por_req;
      any_rst = clear_src || opcode_req || req.watchdog || req.parity
         || req.bad_access || req.low_voltage;
      lvd_only = req.low_voltage && !clear_src && !opcode_req
         && !req.watchdog && !req.parity && !req.bad_access;
      cause_rd = sfr_rd && sfr_addr == rsr_pkg::CAUSE_ADDR;
      case ({detector_option_mode_hi, detector_option_mode_lo})
         2'b11: lvl_default = rsr_pkg::DET_LVL_RST_11;
         2'b01: lvl_default = rsr_pkg::DET_LVL_RST_01;
         default: lvl_default = rsr_pkg::DET_LVL_RST_10;
      endcase

      // Read data: cause byte with reserved bits zero
      st_nxt.rd_data = 8'h00;
      if (cause_rd) begin
         st_nxt.rd_data = st_r.cause;
      end

      // Cause flags: pin/power-on clear wins over sets; sets win over a read clear
      if (clear_src || cause_rd) begin
         st_nxt.cause = rsr_pkg::CAUSE_RST;
      end
      if (!clear_src) begin
         if (opcode_req) begin
            st_nxt.cause[rsr_pkg::BIT_OPCODE] = 1'b1;
         end
         if (req.watchdog) begin
            st_nxt.cause[rsr_pkg::BIT_WDOG] = 1'b1;
         end
         if (req.parity) begin
            st_nxt.cause[rsr_pkg::BIT_PARITY] = 1'b1;
         end
         if (req.bad_access) begin
            st_nxt.cause[rsr_pkg::BIT_ACCESS] = 1'b1;
         end
         if (req.low_voltage) begin
            st_nxt.cause[rsr_pkg::BIT_LOWV] = 1'b1;
         end
      end

      // Software writes to detector and parity controls
      if (!any_rst) begin
         if (det_ctrl_wr) begin
            st_nxt.det_ctrl = sfr_wdata;
         end
         if (det_level_wr) begin
            st_nxt.det_level = sfr_wdata;
         end
         if (parity_dis_wr) begin
            st_nxt.parity_reset_disable = sfr_wdata[0];
         end
         if (voltage_drop_interrupt && detector_option_mode_hi
             && !detector_option_mode_lo) begin
            st_nxt.det_level[rsr_pkg::BIT_LVL_MODE] = 1'b1;
            st_nxt.det_level[rsr_pkg::BIT_LVL_SEL] = 1'b1;
         end
      end

      // Reset effects on held settings and peripherals
      st_nxt.internal_reset = any_rst;
      st_nxt.pc_undefined = any_rst;
      st_nxt.load_init = any_rst;
      if (any_rst) begin
         st_nxt.parity_reset_disable = 1'b0;
         if (!lvd_only) begin
            st_nxt.det_ctrl = rsr_pkg::DET_CTRL_RST;
            st_nxt.det_level = lvl_default;
         end
         init_nxt.irq_flags = rsr_pkg::IRQ_FLAG_RST;
         init_nxt.irq_mask = rsr_pkg::IRQ_MASK_RST;
         init_nxt.irq_prio = rsr_pkg::IRQ_PRIO_RST;
         init_nxt.serial_channel_mode = rsr_pkg::SER_MODE_RST;
         init_nxt.serial_channel_setting =
            rsr_pkg::SER_SET_RST;
         init_nxt.serial_output_levels = rsr_pkg::SER_OUT_RST;
         init_nxt.compare_upper_limit =
            rsr_pkg::CMP_UPPER_RST;
         init_nxt.compare_lower_limit =
            rsr_pkg::CMP_LOWER_RST;
         init_nxt.conversion_result =
            rsr_pkg::CONV_RESULT_RST;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         st_r <= '0;
         st_r.det_level <= rsr_pkg::DET_LVL_RST_10;
         st_r.internal_reset <= 1'b1;
         st_r.pc_undefined <= 1'b1;
         init_r.irq_flags <= rsr_pkg::IRQ_FLAG_RST;
         init_r.irq_mask <= rsr_pkg::IRQ_MASK_RST;
         init_r.irq_prio <= rsr_pkg::IRQ_PRIO_RST;
         init_r.serial_channel_mode <= rsr_pkg::SER_MODE_RST;
         init_r.serial_channel_setting <= rsr_pkg::SER_SET_RST;
         init_r.serial_output_levels <= rsr_pkg::SER_OUT_RST;
         init_r.compare_upper_limit <= rsr_pkg::CMP_UPPER_RST;
         init_r.compare_lower_limit <= rsr_pkg::CMP_LOWER_RST;
         init_r.conversion_result <= rsr_pkg::CONV_RESULT_RST;
      end else begin
         st_r <= st_nxt;
         init_r <= init_nxt;
      end
   end

   assign sfr_rdata = st_r.rd_data;
   assign internal_reset = st_r.internal_reset;
   assign pc_undefined = st_r.pc_undefined;
   assign voltage_detect_control = st_r.det_ctrl;
   assign detection_level_select = st_r.det_level;
   assign parity_reset_disable = st_r.parity_reset_disable;
   assign reset_cause_flags = st_r.cause;
   assign init_values = init_r;

endmodule : rsr_core

// ### pkg/rsr_pkg.sv
// Package for the reset source recorder: offsets, field positions,
// reset values and the carrier structs shared by the core.
// Assumes a synchronous system clock domain and a byte-wide SFR port.
package rsr_pkg;

   // Register map
   localparam logic [19:0] CAUSE_ADDR = 20'hf_ffa8;

   // Cause register field positions
   localparam int unsigned BIT_OPCODE = 7;
   localparam int unsigned BIT_WDOG = 4;
   localparam int unsigned BIT_PARITY = 2;
   localparam int unsigned BIT_ACCESS = 1;
   localparam int unsigned BIT_LOWV = 0;

   // Detection-level register field positions
   localparam int unsigned BIT_LVL_MODE = 7;
   localparam int unsigned BIT_LVL_SEL = 0;

   // Illegal instruction byte
   localparam logic [7:0] OPCODE_ILLEGAL = 8'hff;

   // Reset values
   localparam logic [7:0] DET_CTRL_RST = 8'h00;
   localparam logic [7:0] DET_LVL_RST_10 = 8'h00;
   localparam logic [7:0] DET_LVL_RST_11 = 8'h81;
   localparam logic [7:0] DET_LVL_RST_01 = 8'h01;
   localparam logic [7:0] IRQ_FLAG_RST = 8'h00;
   localparam logic [7:0] IRQ_MASK_RST = 8'hff;
   localparam logic [7:0] IRQ_PRIO_RST = 8'hff;
   localparam logic [15:0] SER_MODE_RST = 16'h0020;
   localparam logic [15:0] SER_SET_RST = 16'h0087;
   localparam logic [15:0] SER_OUT_RST = 16'h0f0f;
   localparam logic [7:0] CMP_UPPER_RST = 8'hff;
   localparam logic [7:0] CMP_LOWER_RST = 8'h00;
   localparam logic [15:0] CONV_RESULT_RST = 16'h0000;
   localparam logic [7:0] CAUSE_RST = 8'h00;

   // Reset requests in
   typedef struct packed {
      logic pin;
      logic supply_fall;
      logic supply_rise;
      logic opcode;
      logic watchdog;
      logic parity;
      logic bad_access;
      logic low_voltage;
   } rsr_req_t;

   // Post-reset values driven to peripherals
   typedef struct packed {
      logic [7:0] irq_flags;
      logic [7:0] irq_mask;
      logic [7:0] irq_prio;
      logic [15:0] serial_channel_mode;
      logic [15:0] serial_channel_setting;
      logic [15:0] serial_output_levels;
      logic [7:0] compare_upper_limit;
      logic [7:0] compare_lower_limit;
      logic [15:0] conversion_result;
   } rsr_init_t;

   // State of the core apart from synchronisers and post-reset values
   typedef struct packed {
      logic [7:0] cause;
      logic [7:0] det_ctrl;
      logic [7:0] det_level;
      logic parity_reset_disable;
      logic power_ok;
      logic internal_reset;
      logic load_init;
      logic [7:0] rd_data;
      logic pc_undefined;
   } rsr_state_t;

endpackage : rsr_pkg

// ### tb/rsr_core_sva.sv
// Port assertions for the reset source recorder core.
// Assumes one clock domain; bound to every rsr_core instance.
`timescale 1ns/1ps
module rsr_core_sva (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Requests and port inputs
   input wire rsr_pkg::rsr_req_t req,
   input wire logic [7:0] exec_opcode,
   input wire logic exec_valid,
   input wire logic debug_mode,
   input wire logic detector_option_mode_hi,
   input wire logic detector_option_mode_lo,
   input wire logic voltage_drop_interrupt,
   input wire logic [19:0] sfr_addr,
   input wire logic sfr_rd,
   input wire logic det_ctrl_wr,
   input wire logic det_level_wr,
   // Outputs
   input wire logic [7:0] sfr_rdata,
   input wire logic internal_reset,
   input wire logic pc_undefined,
   input wire logic [7:0] voltage_detect_control,
   input wire logic [7:0] detection_level_select,
   input wire logic parity_reset_disable,
   input wire logic [7:0] reset_cause_flags
);
   logic [2:0] clr_r;
   logic quiet, nlv, op_hit, rd_hit, srq;
   always_ff @(posedge clock) begin
      clr_r <= reset ? 3'h0 : {clr_r[1:0], req.pin | req.supply_fall};
   end
   // No pin or supply clear in flight
   assign quiet = ~|clr_r && !req.pin && !req.supply_fall;
   assign op_hit = exec_valid && exec_opcode == 8'hff && !debug_mode;
   assign nlv = req.opcode || req.watchdog || req.parity || req.bad_access;
   assign srq = nlv || req.low_voltage;
   assign rd_hit = sfr_rd && sfr_addr == rsr_pkg::CAUSE_ADDR;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   a_read_data: assert property (rd_hit |=>
      sfr_rdata == $past(reset_cause_flags)) else $error("bad read data");
   a_read_clear: assert property (rd_hit && quiet && !srq &&
      !op_hit && !$past(op_hit) |=> reset_cause_flags == 8'h00)
      else $error("no clear");
   a_resv_zero: assert property (
      (reset_cause_flags & 8'h68) == 8'h00) else $error("reserved bit set");
   a_wdog_set: assert property (req.watchdog && quiet |=>
      reset_cause_flags[4]) else $error("watchdog flag not set");
   a_flags_held: assert property (srq && quiet && !rd_hit |=>
      (reset_cause_flags & $past(reset_cause_flags)) ==
      $past(reset_cause_flags)) else $error("cause flag lost");
   a_opcode_trap: assert property (op_hit && quiet |->
      ##[1:3] reset_cause_flags[7]) else $error("opcode flag not set");
   a_clr_reset: assert property (clr_r[2] |->
      ##[0:2] internal_reset) else $error("no internal reset");
   a_pc_follows: assert property (srq |=>
      pc_undefined && internal_reset) else $error("pc state wrong");
   a_ctrl_clear: assert property (nlv |-> ##[1:3]
      voltage_detect_control == 8'h00 && !parity_reset_disable)
      else $error("controls not cleared");
   a_level_load: assert property (nlv &&
      detector_option_mode_hi && detector_option_mode_lo |-> ##[1:3]
      detection_level_select == 8'h81) else $error("level not loaded");
   a_lowv_keep: assert property (req.low_voltage && quiet &&
      !nlv && !op_hit && !det_ctrl_wr && !det_level_wr &&
      !voltage_drop_interrupt |=> $stable(voltage_detect_control))
      else $error("control lost");
endmodule : rsr_core_sva
bind rsr_core rsr_core_sva u_rsr_core_sva (.clock(clock), .reset(reset),
   .req(req), .exec_opcode(exec_opcode), .exec_valid(exec_valid),
   .debug_mode(debug_mode),
   .detector_option_mode_hi(detector_option_mode_hi),
   .detector_option_mode_lo(detector_option_mode_lo),
   .voltage_drop_interrupt(voltage_drop_interrupt), .sfr_addr(sfr_addr),
   .sfr_rd(sfr_rd), .det_ctrl_wr(det_ctrl_wr), .det_level_wr(det_level_wr),
   .sfr_rdata(sfr_rdata), .internal_reset(internal_reset),
   .pc_undefined(pc_undefined),
   .voltage_detect_control(voltage_detect_control),
   .detection_level_select(detection_level_select),
   .parity_reset_disable(parity_reset_disable),
   .reset_cause_flags(reset_cause_flags));

// ### tb/tb.sv
// Bench for the reset source recorder core.
// Assumes the core alone, driven and watched at its ports.
`timescale 1ns/1ps
module tb;
   rsr_pkg::rsr_req_t req = '0;
   rsr_pkg::rsr_init_t iv;
   logic clock = 0, reset = 1, ev = 0, dbg = 0, mhi = 1, mlo = 0, vdi = 0;
   logic rd = 0, wr = 0, cw = 0, lw = 0, pw = 0, rd_seen = 0, irst, prd, pc;
   logic [7:0] op = 0, wd = 0, rdat, vdc, dls, rcf;
   logic [19:0] adr = 0;
   logic [7:0] q[$];
   int mismatches = 0, compares = 0, i;
   always #25 clock = ~clock;
   rsr_core u_rsr_core (.clock(clock), .reset(reset), .req(req),
      .exec_opcode(op), .exec_valid(ev), .debug_mode(dbg),
      .detector_option_mode_hi(mhi), .detector_option_mode_lo(mlo),
      .voltage_drop_interrupt(vdi), .sfr_addr(adr), .sfr_rd(rd),
      .sfr_wr(wr), .sfr_wdata(wd), .det_ctrl_wr(cw), .det_level_wr(lw),
      .parity_dis_wr(pw), .sfr_rdata(rdat), .internal_reset(irst),
      .pc_undefined(pc), .voltage_detect_control(vdc),
      .detection_level_select(dls), .parity_reset_disable(prd),
      .reset_cause_flags(rcf), .init_values(iv));
   task chk(input logic [103:0] s, input logic [103:0] e, input string n);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   task wrap_up;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   always @(posedge clock) rd_seen <= rd;
   always @(negedge clock) begin
      if (rd_seen) begin
         chk(rdat, q.pop_front(), "rdata");
      end
   end
   task settle;
      int n;
      repeat (4) @(posedge clock);
      for (n = 0; n < 20 && irst !== 1'b0; n++) @(posedge clock);
      @(negedge clock);
   endtask : settle
   // Toggles request bits for one cycle
   task hit(input logic [7:0] m);
      @(posedge clock);
      req <= req ^ m;
      @(posedge clock);
      req <= req ^ m;
      settle;
   endtask : hit
   task rdn(input logic [19:0] a, input logic [7:0] e, input int n);
      @(posedge clock);
      adr <= a;
      rd <= 1;
      repeat (n) begin
         q.push_back(e);
         e = 8'h00;
         @(posedge clock);
      end
      rd <= 0;
   endtask : rdn
   initial begin
      logic [7:0] src [5] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
      logic [7:0] flg [5] = '{8'h80, 8'h10, 8'h04, 8'h02, 8'h01};
      logic [7:0] lv [3] = '{8'h00, 8'h81, 8'h01};
      void'($urandom(38));
      repeat (4) @(posedge clock);
      reset <= 0;
      repeat (6) @(negedge clock);
      chk({irst, pc}, 2'b11, "power hold");
      @(posedge clock);
      req.supply_rise <= 1;
      settle;
      chk({irst, pc}, 2'b00, "release");
      chk(iv, {8'h00, 8'hff, 8'hff, 16'h0020,
         16'h0087, 16'h0f0f, 8'hff, 8'h00,
         16'h0000}, "init");
      for (i = 0; i < 5; i++) begin
         hit(src[i]);
         rdn(rsr_pkg::CAUSE_ADDR, flg[i], 2);
      end
      hit(8'h08);
      hit(8'h04);
      @(posedge clock);
      adr <= rsr_pkg::CAUSE_ADDR;
      wr <= 1;
      wd <= 8'($urandom);
      @(posedge clock);
      wr <= 0;
      rdn(20'h0_0100, 8'h00, 1);
      rdn(rsr_pkg::CAUSE_ADDR, 8'h14, 1);
      for (i = 0; i < 3; i++) begin
         @(posedge clock);
         dbg <= (i == 1);
         op <= (i == 2) ? 8'($urandom_range(254)) : 8'hff;
         ev <= 1;
         @(posedge clock);
         ev <= 0;
         settle;
         rdn(rsr_pkg::CAUSE_ADDR, {i == 0, 7'h00}, 1);
      end
      hit(8'h01);
      hit(8'h80);
      rdn(rsr_pkg::CAUSE_ADDR, 8'h00, 1);
      hit(8'h02);
      hit(8'h60);
      rdn(rsr_pkg::CAUSE_ADDR, 8'h00, 1);
      for (i = 0; i < 3; i++) begin
         @(posedge clock);
         {mhi, mlo} <= (i == 2) ? 2'b01 : {1'b1, i == 1};
         {cw, lw, pw, wd} <= {3'b111, 8'($urandom)};
         @(posedge clock);
         {cw, lw, pw} <= 3'b000;
         hit(8'h01);
         chk({vdc, dls, prd}, {wd, wd, 1'b0}, "keep");
         hit(8'h02);
         chk({vdc, prd}, 9'h000, "ctrl");
         chk(dls, lv[i], "level");
      end
      @(posedge clock);
      {mhi, mlo} <= 2'b10;
      vdi <= 1;
      @(posedge clock);
      vdi <= 0;
      repeat (2) @(negedge clock);
      chk(dls, 8'h81, "auto level");
      wrap_up;
   end
   initial begin
      repeat (3000) @(posedge clock);
      mismatches++;
      wrap_up;
   end
endmodule : tb
